//--- hdl/pste_map.svh
// constants of the status trace encoder: codes, markers, counts, buffer shape
`ifndef PSTE_MAP_SVH
`define PSTE_MAP_SVH

// status codes
`define PSTE_CODE_CONT 5'h00
`define PSTE_CODE_BEGIN 5'h01
`define PSTE_CODE_USER 5'h03
`define PSTE_CODE_MARK 5'h04
`define PSTE_CODE_TAKEN 5'h05
`define PSTE_CODE_RTE 5'h07

// data byte-count markers
`define PSTE_MARK_D1 5'h08
`define PSTE_MARK_D2 5'h09
`define PSTE_MARK_D4 5'h0b

// address byte-count markers
`define PSTE_MARK_A2 5'h0d
`define PSTE_MARK_A3 5'h0e

// compressed run codes: base plus count
`define PSTE_CODE_RUN_BASE 5'h10
`define PSTE_RUN_MAX 4'ha

// nibbles per payload size
`define PSTE_NIB_D1 4'h2
`define PSTE_NIB_D2 4'h4
`define PSTE_NIB_D4 4'h8
`define PSTE_NIB_A2 4'h4
`define PSTE_NIB_A3 4'h6

// trace buffer shape: flag bit plus 5-bit value, 64 entries
`define PSTE_TB_WIDTH 6
`define PSTE_TB_AW 6
`define PSTE_TB_DEPTH 64

// reset values
`define PSTE_RST_CODE 5'h00
`define PSTE_RST_PTR 6'h00

`endif

//--- hdl/pste_pkg.sv
// types of the status trace encoder
package pste_pkg;

  // kind of instruction beginning in a cycle
  typedef enum logic [2:0] {
    PSTE_KIND_SEQ = 3'b000,
    PSTE_KIND_BRANCH = 3'b001,
    PSTE_KIND_RTE = 3'b010,
    PSTE_KIND_PULSE = 3'b011,
    PSTE_KIND_WRITE_DEBUG_DATA_INSTRUCTION = 3'b100
  } pste_kind_type;

  // operand size
  typedef enum logic [1:0] {
    PSTE_SIZE_BYTE = 2'b00,
    PSTE_SIZE_WORD = 2'b01,
    PSTE_SIZE_LONG = 2'b10
  } pste_size_type;

  // branch target bytes chosen by configuration
  typedef enum logic [1:0] {
    PSTE_ABYTES_NONE = 2'b00,
    PSTE_ABYTES_TWO = 2'b01,
    PSTE_ABYTES_THREE = 2'b10
  } pste_abytes_type;

  // sequencer states
  typedef enum logic [1:0] {
    PSTE_ST_RUN = 2'b00,
    PSTE_ST_CODE = 2'b01,
    PSTE_ST_DATA = 2'b10
  } pste_state_type;

endpackage : pste_pkg

//--- hdl/pste_trace_ram.sv
// trace buffer memory: one write port, one read port with registered data
`timescale 1ns/1ps
`include "pste_map.svh"

module pste_trace_ram (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic ce,
  input wire logic wr_en,
  input wire logic [`PSTE_TB_AW-1:0] wr_addr,
  input wire logic [`PSTE_TB_WIDTH-1:0] wr_data,
  input wire logic [`PSTE_TB_AW-1:0] rd_addr,
  output logic [`PSTE_TB_WIDTH-1:0] rd_data_q
);

  // storage, no reset: contents are only valid behind the write pointer
  logic [`PSTE_TB_WIDTH-1:0] mem [`PSTE_TB_DEPTH];

  // write port
  always_ff @(posedge mclk) begin
    if (ce && wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // read port, one cycle latency
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rd_data_q <= '0;
    end else if (ce) begin
      rd_data_q <= mem[rd_addr];
    end
  end

endmodule : pste_trace_ram

//--- hdl/pste_nibble_ser.sv
// payload serializer: one marker, then the payload nibble by nibble
`timescale 1ns/1ps
`include "pste_map.svh"

module pste_nibble_ser (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic ce,
  input wire logic load,
  input wire logic [4:0] marker,
  input wire logic [3:0] nibbles,
  input wire logic [31:0] word,
  output logic out_valid,
  output logic out_is_nibble,
  output logic [4:0] out_value,
  output logic busy_q
);

  logic mark_q; // marker still to go
  logic mark_d;
  logic busy_d;
  logic [4:0] marker_q; // held marker
  logic [4:0] marker_d;
  logic [31:0] word_q; // remaining payload, low nibble next
  logic [31:0] word_d;
  logic [3:0] left_q; // nibbles still to go
  logic [3:0] left_d;

  // output item and next state
  always_comb begin
    mark_d = mark_q;
    busy_d = busy_q;
    marker_d = marker_q;
    word_d = word_q;
    left_d = left_q;
    out_valid = busy_q;
    out_is_nibble = busy_q && !mark_q;
    out_value = mark_q ? marker_q : {1'b0, word_q[3:0]};
    if (load) begin
      // marker goes out one cycle before the first nibble
      mark_d = 1'b1;
      busy_d = 1'b1;
      marker_d = marker;
      word_d = word;
      left_d = nibbles;
    end else if (busy_q && mark_q) begin
      mark_d = 1'b0;
    end else if (busy_q) begin
      // low nibble first
      word_d = {4'h0, word_q[31:4]};
      left_d = left_q - 4'h1;
      if (left_q == 4'h1) begin
        busy_d = 1'b0;
      end
    end
  end

  // register the serializer state
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      mark_q <= 1'b0;
      busy_q <= 1'b0;
      marker_q <= `PSTE_RST_CODE;
      word_q <= 32'h0000_0000;
      left_q <= 4'h0;
    end else if (ce) begin
      mark_q <= mark_d;
      busy_q <= busy_d;
      marker_q <= marker_d;
      word_q <= word_d;
      left_q <= left_d;
    end
  end

endmodule : pste_nibble_ser

//--- hdl/pste_encoder.sv
// status trace encoder: code generation, run compression, trace recording
`timescale 1ns/1ps
`include "pste_map.svh"

module pste_encoder (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic ce,
  input wire logic core_begin,
  input wire pste_pkg::pste_kind_type core_kind,
  input wire logic core_continue,
  input wire logic core_user_entry,
  input wire logic core_sync_program_counter_command,
  input wire logic core_indirect,
  input wire logic [31:0] core_target,
  input wire logic [31:0] core_operand,
  input wire pste_pkg::pste_size_type core_op_size,
  input wire logic periph_valid,
  input wire logic [31:0] periph_data,
  input wire pste_pkg::pste_size_type periph_size,
  input wire pste_pkg::pste_abytes_type cfg_addr_bytes,
  input wire logic cfg_data_trace,
  input wire logic cfg_compress,
  input wire logic [`PSTE_TB_AW-1:0] tb_rd_addr,
  output logic core_stall_q,
  output logic [4:0] processor_status_code_q,
  output logic [3:0] debug_data_nibble_q,
  output logic debug_data_valid_q,
  output logic [`PSTE_TB_WIDTH-1:0] status_trace_buffer_rdata_q,
  output logic [`PSTE_TB_AW-1:0] tb_wr_ptr_q,
  output logic tb_wrapped_q
);
  import pste_pkg::*;

  // marker for an operand size
  function automatic logic [4:0] size_marker(input pste_size_type sz);
    logic [4:0] m;
    m = `PSTE_MARK_D4;
    unique case (sz)
      PSTE_SIZE_BYTE: m = `PSTE_MARK_D1;
      PSTE_SIZE_WORD: m = `PSTE_MARK_D2;
      default: m = `PSTE_MARK_D4;
    endcase
    return m;
  endfunction : size_marker

  // nibble count for an operand size
  function automatic logic [3:0] size_nibbles(input pste_size_type sz);
    logic [3:0] n;
    n = `PSTE_NIB_D4;
    unique case (sz)
      PSTE_SIZE_BYTE: n = `PSTE_NIB_D1;
      PSTE_SIZE_WORD: n = `PSTE_NIB_D2;
      default: n = `PSTE_NIB_D4;
    endcase
    return n;
  endfunction : size_nibbles

  // decoded event of this cycle
  logic ev_valid; // something to report
  logic ev_has_code; // carries a status code
  logic [4:0] ev_code; // that code
  logic ev_data; // carries a payload
  logic [4:0] ev_marker; // payload marker
  logic [3:0] ev_nib; // payload nibbles
  logic [31:0] ev_word; // payload value
  logic ev_seq_one; // plain begin code, a compression candidate

  // sequencer state
  pste_state_type st_q;
  pste_state_type st_d;
  logic [3:0] cnt_q; // held-back begin codes
  logic [3:0] cnt_d;
  logic held_has_q; // event parked behind a count flush
  logic held_has_d;
  logic [4:0] held_code_q;
  logic [4:0] held_code_d;
  logic held_data_q;
  logic held_data_d;
  logic [4:0] held_marker_q;
  logic [4:0] held_marker_d;
  logic [3:0] held_nib_q;
  logic [3:0] held_nib_d;
  logic [31:0] held_word_q;
  logic [31:0] held_word_d;
  logic [4:0] run_code; // code for the current count
  logic main_wr; // sequencer writes a code this cycle
  logic [4:0] main_code;
  logic ser_load;
  logic [4:0] ser_marker;
  logic [3:0] ser_nib;
  logic [31:0] ser_word;

  // serializer output
  logic ser_valid;
  logic ser_is_nib;
  logic [4:0] ser_value;
  logic ser_busy;

  // stream write and output registers
  logic tb_wr;
  logic [`PSTE_TB_WIDTH-1:0] tb_item;
  logic core_stall_d;
  logic [4:0] psc_d;
  logic [3:0] ddn_d;
  logic ddv_d;
  logic [`PSTE_TB_AW-1:0] ptr_d;
  logic wrapped_d;

  // event decode; one event per cycle, highest priority first
  always_comb begin
    ev_valid = 1'b0;
    ev_has_code = 1'b0;
    ev_code = `PSTE_CODE_CONT;
    ev_data = 1'b0;
    ev_marker = `PSTE_MARK_D4;
    ev_nib = `PSTE_NIB_D4;
    ev_word = 32'h0000_0000;
    if (core_user_entry) begin
      // core signals this after the instruction has completed
      ev_valid = 1'b1;
      ev_has_code = 1'b1;
      ev_code = `PSTE_CODE_USER;
    end else if (core_sync_program_counter_command) begin
      ev_valid = 1'b1;
      ev_has_code = 1'b1;
      ev_code = `PSTE_CODE_TAKEN;
    end else if (core_begin) begin
      ev_valid = 1'b1;
      ev_has_code = 1'b1;
      unique case (core_kind)
        PSTE_KIND_SEQ: begin
          ev_code = `PSTE_CODE_BEGIN;
        end
        PSTE_KIND_BRANCH: begin
          ev_code = `PSTE_CODE_TAKEN;
          // relative targets are known from the program image
          if (core_indirect && cfg_addr_bytes == PSTE_ABYTES_TWO) begin
            ev_data = 1'b1;
            ev_marker = `PSTE_MARK_A2;
            ev_nib = `PSTE_NIB_A2;
            ev_word = {16'h0000, core_target[16:1]};
          end else if (core_indirect && cfg_addr_bytes == PSTE_ABYTES_THREE) begin
            ev_data = 1'b1;
            ev_marker = `PSTE_MARK_A3;
            ev_nib = `PSTE_NIB_A3;
            ev_word = {8'h00, core_target[24:1]};
          end
        end
        PSTE_KIND_RTE: begin
          ev_code = `PSTE_CODE_RTE;
        end
        PSTE_KIND_PULSE, PSTE_KIND_WRITE_DEBUG_DATA_INSTRUCTION: begin
          // no configuration bit gates this payload
          ev_code = `PSTE_CODE_MARK;
          ev_data = 1'b1;
          ev_marker = size_marker(core_op_size);
          ev_nib = size_nibbles(core_op_size);
          ev_word = core_operand;
        end
        default: begin
          // illegal kind still counts as one instruction
          ev_code = `PSTE_CODE_BEGIN;
        end
      endcase
    end else if (periph_valid && cfg_data_trace) begin
      // operand capture has no code of its own, only its marker
      ev_valid = 1'b1;
      ev_data = 1'b1;
      ev_marker = size_marker(periph_size);
      ev_nib = size_nibbles(periph_size);
      ev_word = periph_data;
    end else if (core_continue) begin
      ev_valid = 1'b1;
      ev_has_code = 1'b1;
      ev_code = `PSTE_CODE_CONT;
    end
    ev_seq_one = ev_valid && ev_has_code && !ev_data &&
                 ev_code == `PSTE_CODE_BEGIN;
  end

  // sequencer: compression, flush ordering and serializer launch
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    held_has_d = held_has_q;
    held_code_d = held_code_q;
    held_data_d = held_data_q;
    held_marker_d = held_marker_q;
    held_nib_d = held_nib_q;
    held_word_d = held_word_q;
    main_wr = 1'b0;
    main_code = `PSTE_CODE_CONT;
    ser_load = 1'b0;
    // a lone held code goes out as a plain begin, 0x11 is not a run code
    if (cnt_q == 4'h1) begin
      run_code = `PSTE_CODE_BEGIN;
    end else begin
      run_code = `PSTE_CODE_RUN_BASE | {1'b0, cnt_q};
    end
    unique case (st_q)
      PSTE_ST_RUN: begin
        if (!ev_valid) begin
          // nothing this cycle, the count keeps waiting
        end else if (ev_seq_one && cfg_compress) begin
          if (cnt_q == `PSTE_RUN_MAX - 4'h1) begin
            main_wr = 1'b1;
            main_code = `PSTE_CODE_RUN_BASE | {1'b0, `PSTE_RUN_MAX};
            cnt_d = 4'h0;
          end else begin
            cnt_d = cnt_q + 4'h1;
          end
        end else if (cnt_q != 4'h0) begin
          // count goes first; the event waits one cycle
          main_wr = 1'b1;
          main_code = run_code;
          cnt_d = 4'h0;
          held_has_d = ev_has_code;
          held_code_d = ev_code;
          held_data_d = ev_data;
          held_marker_d = ev_marker;
          held_nib_d = ev_nib;
          held_word_d = ev_word;
          st_d = PSTE_ST_CODE;
        end else begin
          main_wr = ev_has_code;
          main_code = ev_code;
          ser_load = ev_data;
          if (ev_data) begin
            st_d = PSTE_ST_DATA;
          end
        end
      end
      PSTE_ST_CODE: begin
        main_wr = held_has_q;
        main_code = held_code_q;
        ser_load = held_data_q;
        st_d = held_data_q ? PSTE_ST_DATA : PSTE_ST_RUN;
      end
      PSTE_ST_DATA: begin
        if (!ser_busy) begin
          st_d = PSTE_ST_RUN;
        end
      end
      default: begin
        st_d = PSTE_ST_RUN;
      end
    endcase
    // payload source: parked event or the live one
    ser_marker = (st_q == PSTE_ST_CODE) ? held_marker_q : ev_marker;
    ser_nib = (st_q == PSTE_ST_CODE) ? held_nib_q : ev_nib;
    ser_word = (st_q == PSTE_ST_CODE) ? held_word_q : ev_word;
  end

  // register the sequencer
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      st_q <= PSTE_ST_RUN;
      cnt_q <= 4'h0;
      held_has_q <= 1'b0;
      held_code_q <= `PSTE_RST_CODE;
      held_data_q <= 1'b0;
      held_marker_q <= `PSTE_MARK_D4;
      held_nib_q <= 4'h0;
      held_word_q <= 32'h0000_0000;
    end else if (ce) begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      held_has_q <= held_has_d;
      held_code_q <= held_code_d;
      held_data_q <= held_data_d;
      held_marker_q <= held_marker_d;
      held_nib_q <= held_nib_d;
      held_word_q <= held_word_d;
    end
  end

  // marker then nibbles, one per cycle
  pste_nibble_ser u_ser (
    .mclk(mclk),
    .reset_n(reset_n),
    .ce(ce),
    .load(ser_load),
    .marker(ser_marker),
    .nibbles(ser_nib),
    .word(ser_word),
    .out_valid(ser_valid),
    .out_is_nibble(ser_is_nib),
    .out_value(ser_value),
    .busy_q(ser_busy)
  );

  // merged stream; sequencer and serializer never write together
  always_comb begin
    tb_wr = main_wr || ser_valid;
    tb_item = ser_valid ? {ser_is_nib, ser_value} : {1'b0, main_code};
    // core must hold its inputs while flush or payload is in flight
    core_stall_d = (st_d != PSTE_ST_RUN);
    psc_d = `PSTE_CODE_CONT;
    ddn_d = debug_data_nibble_q;
    ddv_d = 1'b0;
    if (ser_valid && ser_is_nib) begin
      ddn_d = ser_value[3:0];
      ddv_d = 1'b1;
    end else if (ser_valid) begin
      psc_d = ser_value;
    end else if (main_wr) begin
      psc_d = main_code;
    end
    ptr_d = tb_wr ? tb_wr_ptr_q + `PSTE_TB_AW'(1) : tb_wr_ptr_q;
    // wrap flag tells the reader that the oldest entries are lost
    wrapped_d = tb_wrapped_q || (tb_wr && (&tb_wr_ptr_q));
  end

  // register the stream outputs and the write pointer
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      core_stall_q <= 1'b0;
      processor_status_code_q <= `PSTE_RST_CODE;
      debug_data_nibble_q <= 4'h0;
      debug_data_valid_q <= 1'b0;
      tb_wr_ptr_q <= `PSTE_RST_PTR;
      tb_wrapped_q <= 1'b0;
    end else if (ce) begin
      core_stall_q <= core_stall_d;
      processor_status_code_q <= psc_d;
      debug_data_nibble_q <= ddn_d;
      debug_data_valid_q <= ddv_d;
      tb_wr_ptr_q <= ptr_d;
      tb_wrapped_q <= wrapped_d;
    end
  end

  // circular trace buffer
  pste_trace_ram u_ram (
    .mclk(mclk),
    .reset_n(reset_n),
    .ce(ce),
    .wr_en(tb_wr),
    .wr_addr(tb_wr_ptr_q),
    .wr_data(tb_item),
    .rd_addr(tb_rd_addr),
    .rd_data_q(status_trace_buffer_rdata_q)
  );

endmodule : pste_encoder

//--- test/pste_encoder_assertions.sv
// concurrent checks on the status trace encoder ports
`timescale 1ns/1ps
module pste_encoder_assertions (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic ce,
  input wire logic core_begin,
  input wire pste_pkg::pste_kind_type core_kind,
  input wire logic core_continue,
  input wire logic core_user_entry,
  input wire logic core_sync_program_counter_command,
  input wire logic periph_valid,
  input wire logic cfg_data_trace,
  input wire logic cfg_compress,
  input wire logic core_stall_q,
  input wire logic [4:0] processor_status_code_q,
  input wire logic debug_data_valid_q
);
  import pste_pkg::*;
  // event taken with compression off, so nothing is held back
  logic take;
  assign take = ce && !core_stall_q && !cfg_compress;
  // a begin with no higher-priority event beside it
  logic beg;
  assign beg = take && core_begin && !core_user_entry && !core_sync_program_counter_command;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  a_no_reserved: assert property (
    !(processor_status_code_q inside {5'h02, 5'h06, 5'h0a, 5'h0c, 5'h0f, 5'h10, 5'h11})
    && processor_status_code_q <= 5'h1a) else $error("reserved status code");
  a_user_code: assert property (take && core_user_entry
    |=> processor_status_code_q == 5'h03) else $error("user entry code wrong");
  a_sync_code: assert property (take && core_sync_program_counter_command && !core_user_entry
    |=> processor_status_code_q == 5'h05) else $error("sync code wrong");
  a_begin_code: assert property (beg && core_kind == PSTE_KIND_SEQ
    |=> processor_status_code_q == 5'h01) else $error("begin code wrong");
  a_rte_code: assert property (beg && core_kind == PSTE_KIND_RTE
    |=> processor_status_code_q == 5'h07) else $error("return code wrong");
  a_cont_code: assert property (take && core_continue && !core_begin
    && !core_user_entry && !core_sync_program_counter_command && !(periph_valid && cfg_data_trace)
    |=> processor_status_code_q == 5'h00) else $error("continue code wrong");
  a_wdd_start: assert property (beg && core_kind == PSTE_KIND_WRITE_DEBUG_DATA_INSTRUCTION
    |=> processor_status_code_q == 5'h04 && core_stall_q) else $error("pulse code wrong");
  a_after_pulse: assert property (processor_status_code_q == 5'h04
    |=> processor_status_code_q inside {5'h08, 5'h09, 5'h0b}) else $error("no data marker");
  a_word_nibs: assert property (processor_status_code_q == 5'h09
    |=> debug_data_valid_q [*4] ##1 !debug_data_valid_q) else $error("word nibble count");
  a_long_nibs: assert property (processor_status_code_q == 5'h0b
    |=> debug_data_valid_q [*8] ##1 !debug_data_valid_q) else $error("long nibble count");
  a_addr3_nibs: assert property (processor_status_code_q == 5'h0e
    |=> debug_data_valid_q [*6] ##1 !debug_data_valid_q) else $error("address nibble count");
  a_stall_ends: assert property ($rose(core_stall_q)
    |-> ##[1:12] !core_stall_q) else $error("stall too long");
endmodule : pste_encoder_assertions

bind pste_encoder pste_encoder_assertions pste_encoder_assertions_inst (.mclk, .reset_n,
  .ce, .core_begin, .core_kind, .core_continue, .core_user_entry, .core_sync_program_counter_command,
  .periph_valid, .cfg_data_trace, .cfg_compress, .core_stall_q,
  .processor_status_code_q, .debug_data_valid_q);

//--- test/pste_core_model.sv
// core pipeline stand-in: one event at a time, held while the encoder stalls
`timescale 1ns/1ps
module pste_core_model (
  input wire logic mclk,
  input wire logic core_stall_q,
  output logic core_begin,
  output pste_pkg::pste_kind_type core_kind,
  output logic core_continue,
  output logic core_user_entry,
  output logic core_sync_program_counter_command,
  output logic core_indirect,
  output logic [31:0] core_target,
  output logic [31:0] core_operand,
  output pste_pkg::pste_size_type core_op_size,
  output logic periph_valid,
  output logic [31:0] periph_data,
  output pste_pkg::pste_size_type periph_size
);
  import pste_pkg::*;
  // wait past any stall; the last event stays on the lines meanwhile
  task hold_off;
    #1;
    while (core_stall_q) begin
      @(posedge mclk);
      #1;
    end
  endtask : hold_off
  // present one event (w: 0 far branch/begin, 1 continue, 2 user, 3 sync,
  // 4 peripheral operand, 5 relative begin); returns at the taking edge
  task ev(input int w, input pste_kind_type k, input logic [31:0] v, input pste_size_type sz);
    hold_off();
    core_begin = (w == 0) || (w == 5);
    core_indirect = (w == 0);
    core_continue = (w == 1);
    core_user_entry = (w == 2);
    core_sync_program_counter_command = (w == 3);
    periph_valid = (w == 4);
    core_kind = k;
    core_target = v;
    core_operand = v;
    periph_data = v;
    core_op_size = sz;
    periph_size = sz;
    @(posedge mclk);
  endtask : ev
  // release: strobes low, data shows inverse so stale values cannot pass
  task idle;
    hold_off();
    core_begin = 1'b0;
    core_continue = 1'b0;
    core_user_entry = 1'b0;
    core_sync_program_counter_command = 1'b0;
    periph_valid = 1'b0;
    core_target = ~core_target;
    core_operand = ~core_operand;
    periph_data = ~periph_data;
  endtask : idle
  // quiet lines at time zero
  initial begin
    core_begin = 1'b0;
    core_continue = 1'b0;
    core_user_entry = 1'b0;
    core_sync_program_counter_command = 1'b0;
    periph_valid = 1'b0;
    core_indirect = 1'b0;
    core_kind = PSTE_KIND_SEQ;
    core_op_size = PSTE_SIZE_BYTE;
    periph_size = PSTE_SIZE_BYTE;
    core_target = 32'h0;
    core_operand = 32'h0;
    periph_data = 32'h0;
  end
endmodule : pste_core_model

//--- test/pste_encoder_tb_top.sv
// self-checking bench for the status trace encoder
`timescale 1ns/1ps
module pste_encoder_tb_top;
  import pste_pkg::*;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic ce = 1'b1; // clock enable, dropped once in mid-payload
  pste_abytes_type cfg_addr_bytes = PSTE_ABYTES_THREE;
  logic cfg_data_trace = 1'b0;
  logic cfg_compress = 1'b0;
  logic [5:0] tb_rd_addr = 6'h00;
  logic core_begin, core_continue, core_user_entry, core_sync_program_counter_command, core_indirect;
  logic periph_valid, core_stall_q, debug_data_valid_q, tb_wrapped_q;
  pste_kind_type core_kind;
  pste_size_type core_op_size, periph_size;
  logic [31:0] core_target, core_operand, periph_data;
  logic [4:0] processor_status_code_q;
  logic [3:0] debug_data_nibble_q;
  logic [5:0] status_trace_buffer_rdata_q, tb_wr_ptr_q;
  logic [5:0] log_q[$], exp_q[$], hist_q[$]; // entries seen, expected, all seen
  logic [5:0] last_ptr = 6'h00;
  int miscompares = 0;
  int checked = 0;

  pste_encoder pste_encoder_inst (.mclk, .reset_n, .ce, .core_begin, .core_kind,
    .core_continue, .core_user_entry, .core_sync_program_counter_command, .core_indirect, .core_target,
    .core_operand, .core_op_size, .periph_valid, .periph_data, .periph_size,
    .cfg_addr_bytes, .cfg_data_trace, .cfg_compress, .tb_rd_addr, .core_stall_q,
    .processor_status_code_q, .debug_data_nibble_q, .debug_data_valid_q,
    .status_trace_buffer_rdata_q, .tb_wr_ptr_q, .tb_wrapped_q);
  pste_core_model pste_core_model_inst (.mclk, .core_stall_q, .core_begin, .core_kind,
    .core_continue, .core_user_entry, .core_sync_program_counter_command, .core_indirect, .core_target,
    .core_operand, .core_op_size, .periph_valid, .periph_data, .periph_size);

  // 100 MHz clock
  always #5 mclk = ~mclk;
  // log every entry the moment the write pointer moves
  always @(negedge mclk) begin
    if (tb_wr_ptr_q !== last_ptr) begin
      log_q.push_back(debug_data_valid_q ? {2'b10, debug_data_nibble_q}
                                         : {1'b0, processor_status_code_q});
      hist_q.push_back(log_q[$]);
      last_ptr = tb_wr_ptr_q;
    end
  end

  task bad(input string m);
    miscompares++;
    $display("MISMATCH %0t %s", $time, m);
  endtask : bad
  // expected code, then expected nibbles low first
  task xc(input logic [4:0] c);
    exp_q.push_back({1'b0, c});
  endtask : xc
  task xn(input logic [31:0] w, input int n);
    for (int i = 0; i < n; i++) exp_q.push_back({2'b10, w[4*i+:4]});
  endtask : xn
  // compare the logged stream whole, then start afresh
  task cmp(input string m);
    checked++;
    if (log_q.size() != exp_q.size()) bad({m, ": entry count"});
    else foreach (exp_q[i]) if (log_q[i] !== exp_q[i]) bad({m, ": entry value"});
    log_q.delete();
    exp_q.delete();
  endtask : cmp
  task go(input int w, input pste_kind_type k, input logic [31:0] v = 32'h0,
          input pste_size_type sz = PSTE_SIZE_BYTE);
    pste_core_model_inst.ev(w, k, v, sz);
  endtask : go
  // let the sequence drain and the monitor catch up
  task fin;
    pste_core_model_inst.idle();
    repeat (3) @(posedge mclk);
  endtask : fin

  // single codes back to back; a relative branch carries no address
  task t_codes;
    go(2, PSTE_KIND_SEQ);
    go(3, PSTE_KIND_SEQ);
    go(0, PSTE_KIND_SEQ);
    go(0, PSTE_KIND_RTE);
    go(5, PSTE_KIND_BRANCH, 32'h0012_3456);
    go(1, PSTE_KIND_SEQ);
    fin();
    xc(5'h03);
    xc(5'h05);
    xc(5'h01);
    xc(5'h07);
    xc(5'h05);
    xc(5'h00);
    cmp("single codes");
  endtask : t_codes
  // pulse and debug-data operands of each size, data trace on for the word size only
  task t_data;
    pste_kind_type k;
    for (int j = 0; j < 2; j++) begin
      for (int i = 0; i < 3; i++) begin
        k = j ? PSTE_KIND_PULSE : PSTE_KIND_WRITE_DEBUG_DATA_INSTRUCTION;
        cfg_data_trace <= i[0];
        go(0, k, 32'h8765_4321, pste_size_type'(i[1:0]));
        fin();
        xc(5'h04);
        xc(i == 2 ? 5'h0b : 5'h08 + 5'(i));
        xn(32'h8765_4321, 2 << i);
        cmp("operand stream");
      end
    end
  endtask : t_data
  // far branch with each configured address length
  task t_addr;
    for (int i = 0; i < 3; i++) begin
      cfg_addr_bytes <= pste_abytes_type'(i[1:0]);
      go(0, PSTE_KIND_BRANCH, 32'h01ab_cdef);
      fin();
      xc(5'h05);
      if (i == 1) xc(5'h0d);
      if (i == 2) xc(5'h0e);
      if (i != 0) xn(32'h01ab_cdef >> 1, i == 1 ? 4 : 6);
      cmp("branch target");
    end
  endtask : t_addr
  // peripheral operand traced only while enabled
  task t_periph;
    logic [5:0] p;
    cfg_data_trace <= 1'b1;
    go(4, PSTE_KIND_SEQ, 32'h0000_5a3c, PSTE_SIZE_WORD);
    // freeze mid-payload: nothing may move while the enable is low
    #1 ce = 1'b0;
    p = tb_wr_ptr_q;
    repeat (4) @(posedge mclk);
    #1;
    checked++;
    if (tb_wr_ptr_q !== p) bad("pointer moved while frozen");
    ce = 1'b1;
    fin();
    cfg_data_trace <= 1'b0;
    go(4, PSTE_KIND_SEQ, 32'h0000_5a3c, PSTE_SIZE_WORD);
    fin();
    xc(5'h09);
    xn(32'h0000_5a3c, 4);
    cmp("peripheral operand");
  endtask : t_periph
  // runs: 3 then exception return, 11 (max 10) then return, 2 then data
  task t_comp;
    cfg_compress <= 1'b1;
    cfg_data_trace <= 1'b1;
    repeat (3) go(0, PSTE_KIND_SEQ);
    go(0, PSTE_KIND_RTE);
    repeat (11) go(0, PSTE_KIND_SEQ);
    go(0, PSTE_KIND_RTE);
    repeat (2) go(0, PSTE_KIND_SEQ);
    go(4, PSTE_KIND_SEQ, 32'h0000_00c5, PSTE_SIZE_BYTE);
    fin();
    cfg_compress <= 1'b0;
    cfg_data_trace <= 1'b0;
    xc(5'h13);
    xc(5'h07);
    xc(5'h1a);
    xc(5'h01);
    xc(5'h07);
    xc(5'h12);
    xc(5'h08);
    xn(32'h0000_00c5, 2);
    cmp("compressed runs");
  endtask : t_comp
  // the buffer holds what was seen, newest three entries
  task t_read;
    for (int k = 1; k <= 3; k++) begin
      tb_rd_addr <= tb_wr_ptr_q - 6'(k);
      @(posedge mclk);
      @(negedge mclk);
      checked++;
      if (status_trace_buffer_rdata_q !== hist_q[hist_q.size() - k]) bad("buffer readback");
      @(posedge mclk);
    end
    // more entries were written than the buffer holds, so it must have wrapped
    checked++;
    if (tb_wrapped_q !== 1'b1) bad("wrap flag not set");
  endtask : t_read

  task summarize;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : summarize

  // main sequence after 16 cycles of reset
  initial begin
    repeat (16) @(posedge mclk);
    reset_n <= 1'b1;
    @(posedge mclk);
    t_codes();
    t_data();
    t_addr();
    t_periph();
    t_comp();
    t_read();
    summarize();
  end
  // watchdog: the run needs well under 2000 cycles
  initial begin
    #200000;
    bad("timeout");
    summarize();
  end
endmodule : pste_encoder_tb_top
